//--- src/ptm_pkg.sv
// Shared constants and types for the periodic timer unit.
package ptm_pkg;

   localparam int CNT_W = 10;

   // Register offsets on the byte-wide register port.
   localparam logic [3:0] ADDR_CONTROL_ZERO = 4'h0;
   localparam logic [3:0] ADDR_CONTROL_ONE = 4'h1;
   localparam logic [3:0] ADDR_COUNT_LOW = 4'h2;
   localparam logic [3:0] ADDR_COUNT_HIGH = 4'h3;
   localparam logic [3:0] ADDR_CMPA_LOW = 4'h4;
   localparam logic [3:0] ADDR_CMPA_HIGH = 4'h5;
   localparam logic [3:0] ADDR_PERIOD_LOW = 4'h6;
   localparam logic [3:0] ADDR_PERIOD_HIGH = 4'h7;
   localparam logic [3:0] ADDR_STATUS = 4'h8;

   // Bit positions.
   localparam int RUN_BIT = 3;
   localparam int FLAG_A_BIT = 0;
   localparam int FLAG_P_BIT = 1;

   // Values after reset and counter constants.
   localparam logic [7:0] REG_RESET = 8'h00;
   localparam logic [9:0] CNT_RESET = 10'h000;
   localparam logic [9:0] CNT_ONE = 10'h001;
   localparam logic [9:0] CNT_MAX = 10'h3FF;

   typedef enum logic [1:0] {
      MODE_COMPARE = 2'h0,
      MODE_CAPTURE = 2'h1,
      MODE_PWM = 2'h2,
      MODE_TIMER = 2'h3
   } ptm_mode_t;

   // Pin-action codes; the meaning depends on the mode.
   localparam logic [1:0] ACT_NONE = 2'h0;
   localparam logic [1:0] ACT_LOW = 2'h1;
   localparam logic [1:0] ACT_HIGH = 2'h2;
   localparam logic [1:0] ACT_TOGGLE = 2'h3;
   localparam logic [1:0] ACT_INACTIVE = 2'h0;
   localparam logic [1:0] ACT_ACTIVE = 2'h1;
   localparam logic [1:0] ACT_WAVE = 2'h2;
   localparam logic [1:0] ACT_SINGLE = 2'h3;

   typedef struct packed {
      ptm_mode_t mode;
      logic [1:0] action;
      logic oc;
      logic inv;
      logic rsv;
      logic cclr;
   } ptm_ctl_t;

   typedef struct packed {
      logic [3:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } ptm_bus_t;

endpackage

//--- src/ptm_top.sv
// Periodic timer unit: counter, comparators A and P, modes and output pin.
//
// Operation
// - Mode field 00 selects compare-match output mode.
// - Clear-source low: clear on P match or overflow; both flags raised.
// - Clear-source high: clear on A match; only A flag raised.
// - Compare A zero with clear-source high: counter runs to 3FF, no A flag.
// - Compare mode: pin changes on A match or run rise, never on P.
// - Pin action on A match: high, low, toggle, or none for zero.
// - Run bit rising edge restores pin to output-level control value.
// - Mode 11 counts and flags like compare mode, pin not driven.
// - Mode 10 is PWM: P sets period, A sets duty, clear-source ignored.
// - PWM period equals period value, or 1024 when it is zero.
// - Duty at or above period gives full-period active output.
// - PWM mode raises separate A and P match flags; single pulse raises only A.
// - PWM pin action enables waveform or forces fixed level.
// - Output-level bit sets PWM polarity; invert bit reverses the pin.
// - Run rising edge or trigger pin edge starts pulse and counter.
// - Pulse ends on run clear or A match; match clears run, flags.
// - Single pulse: counter zeroes only on run rise; period ignored.
// - Counter readable as low byte and high byte bits 9 to 8.
// - Compare A held in low byte plus high bits 1 to 0, reset zero.
// - Period held in low byte plus high bits 1 to 0, reset zero.
// - Run rise zeroes counter; run fall stops and keeps the count.
// - Compare pin actions 01, 10, 11: low, high, toggle.
`timescale 1ns/100ps
`default_nettype none

module ptm_top
   import ptm_pkg::*;
#(
   parameter int WIDTH = CNT_W
) (
   input wire logic clk,
   input wire logic resetn,
   input wire ptm_bus_t bus_req,
   output logic [7:0] rdata,
   input wire logic external_trigger_pin,
   output logic timer_output_pin,
   output logic timer_output_oe,
   output logic match_a_flag,
   output logic match_p_flag
);

   if (WIDTH != 10) begin : g_width_check
      $error("ptm_top supports a 10-bit counter only");
   end

   function automatic logic wr_at(input ptm_bus_t b, input logic [3:0] a);
      return b.wr && (b.addr == a);
   endfunction

   function automatic logic nz(input logic [9:0] v);
      return v != CNT_RESET;
   endfunction

   // Maps an active or inactive state onto the selected active level.
   function automatic logic act_level(input logic active, input logic oc);
      return active ? oc : ~oc;
   endfunction

   logic run_r;
   logic run_nxt;
   logic run_prev_r;
   logic run_prev_nxt;
   logic [9:0] cnt_r;
   logic [9:0] cnt_nxt;
   logic [9:0] cmpa_r;
   logic [9:0] cmpa_nxt;
   logic [9:0] per_r;
   logic [9:0] per_nxt;
   ptm_ctl_t ctl_r;
   ptm_ctl_t ctl_nxt;
   logic flag_a_r;
   logic flag_a_nxt;
   logic flag_p_r;
   logic flag_p_nxt;
   logic lvl_r;
   logic lvl_nxt;
   logic pin_r;
   logic pin_nxt;
   logic oe_r;
   logic oe_nxt;
   logic [7:0] rdata_r;
   logic [7:0] rdata_nxt;
   logic trig_s1_r;
   logic trig_s2_r;
   logic trig_s3_r;

   logic rise;
   logic counting;
   logic single;
   logic at_max;
   logic hit_a;
   logic hit_p;
   logic pwm_end;
   logic clear;
   logic ev_a;
   logic ev_p;
   logic trig_edge;
   logic pwm_active;
   logic [9:0] cnt_inc;
   logic [9:0] per_less;

   // Trigger pin synchroniser; the third stage only feeds the edge detector.
   // A trigger costs three cycles; a pin pulse under one cycle may be lost.
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         trig_s1_r <= 1'b0;
         trig_s2_r <= 1'b0;
         trig_s3_r <= 1'b0;
      end else begin
         trig_s1_r <= external_trigger_pin;
         trig_s2_r <= trig_s1_r;
         trig_s3_r <= trig_s2_r;
      end
   end

   // Counter, comparators and events.
   // Events land in the flags one edge later, the same edge as the pin.
   always_comb begin
      rise = run_r & ~run_prev_r;
      counting = run_r & ~rise;
      single = (ctl_r.mode == MODE_PWM) && (ctl_r.action == ACT_SINGLE);
      at_max = cnt_r == CNT_MAX;
      cnt_inc = cnt_r + CNT_ONE;
      per_less = per_r - CNT_ONE;
      hit_a = nz(cmpa_r) && (cnt_r == cmpa_r);
      hit_p = nz(per_r) ? (cnt_r == per_r) : at_max;
      pwm_end = nz(per_r) ? (cnt_r == per_less) : at_max;
      trig_edge = trig_s2_r & ~trig_s3_r;
      clear = 1'b0;
      ev_a = 1'b0;
      ev_p = 1'b0;
      cnt_nxt = cnt_r;
      // Run rise zeroes, run low holds.
      if (rise) begin
         cnt_nxt = CNT_RESET;
      end else if (run_r) begin
         unique case (ctl_r.mode)
            MODE_COMPARE, MODE_TIMER: begin
               ev_a = hit_a;
               if (ctl_r.cclr) begin
                  clear = nz(cmpa_r) ? hit_a : at_max;
               end else begin
                  ev_p = hit_p;
                  clear = hit_p;
               end
               cnt_nxt = clear ? CNT_RESET : cnt_inc;
            end
            MODE_PWM: begin
               if (single) begin
                  ev_a = hit_a;
                  cnt_nxt = cnt_inc;
               end else begin
                  ev_a = hit_a;
                  ev_p = pwm_end;
                  cnt_nxt = pwm_end ? CNT_RESET : cnt_inc;
               end
            end
            MODE_CAPTURE: begin
               cnt_nxt = cnt_inc;
            end
         endcase
      end
   end

   // Register file, run bit and flags.
   always_comb begin
      ctl_nxt = ctl_r;
      cmpa_nxt = cmpa_r;
      per_nxt = per_r;
      run_nxt = run_r;
      run_prev_nxt = run_r;
      flag_a_nxt = flag_a_r;
      flag_p_nxt = flag_p_r;
      if (wr_at(bus_req, ADDR_CONTROL_ONE)) begin
         ctl_nxt = ptm_ctl_t'(bus_req.wdata);
         ctl_nxt.rsv = 1'b0;
      end
      if (wr_at(bus_req, ADDR_CMPA_LOW)) begin
         cmpa_nxt[7:0] = bus_req.wdata;
      end
      if (wr_at(bus_req, ADDR_CMPA_HIGH)) begin
         cmpa_nxt[9:8] = bus_req.wdata[1:0];
      end
      if (wr_at(bus_req, ADDR_PERIOD_LOW)) begin
         per_nxt[7:0] = bus_req.wdata;
      end
      if (wr_at(bus_req, ADDR_PERIOD_HIGH)) begin
         per_nxt[9:8] = bus_req.wdata[1:0];
      end
      if (single && trig_edge) begin
         run_nxt = 1'b1;
      end
      if (single && ev_a) begin
         run_nxt = 1'b0;
      end
      // A software write in the same cycle wins over the hardware changes.
      if (wr_at(bus_req, ADDR_CONTROL_ZERO)) begin
         run_nxt = bus_req.wdata[RUN_BIT];
      end
      // Write one to clear; a new event in the same cycle still sets.
      if (wr_at(bus_req, ADDR_STATUS)) begin
         if (bus_req.wdata[FLAG_A_BIT]) begin
            flag_a_nxt = 1'b0;
         end
         if (bus_req.wdata[FLAG_P_BIT]) begin
            flag_p_nxt = 1'b0;
         end
      end
      if (ev_a) begin
         flag_a_nxt = 1'b1;
      end
      if (ev_p) begin
         flag_p_nxt = 1'b1;
      end
   end

   // Output pin.
   always_comb begin
      lvl_nxt = lvl_r;
      if (rise) begin
         lvl_nxt = ctl_r.oc;
      end else if ((ctl_r.mode == MODE_COMPARE) && ev_a) begin
         unique case (ctl_r.action)
            ACT_NONE: lvl_nxt = lvl_r;
            ACT_LOW: lvl_nxt = 1'b0;
            ACT_HIGH: lvl_nxt = 1'b1;
            ACT_TOGGLE: lvl_nxt = ~lvl_r;
         endcase
      end
      // Duty at or above period stays active.
      pwm_active = counting && (cnt_r < cmpa_r);
      pin_nxt = 1'b0;
      oe_nxt = 1'b0;
      unique case (ctl_r.mode)
         MODE_COMPARE: begin
            // Only A events and the run rise move the level.
            pin_nxt = lvl_nxt ^ ctl_r.inv;
            oe_nxt = 1'b1;
         end
         MODE_PWM: begin
            oe_nxt = 1'b1;
            unique case (ctl_r.action)
               ACT_INACTIVE: pin_nxt = act_level(1'b0, ctl_r.oc) ^ ctl_r.inv;
               ACT_ACTIVE: pin_nxt = act_level(1'b1, ctl_r.oc) ^ ctl_r.inv;
               ACT_WAVE: pin_nxt = act_level(pwm_active, ctl_r.oc) ^ ctl_r.inv;
               ACT_SINGLE: pin_nxt = act_level(run_r, ctl_r.oc) ^ ctl_r.inv;
            endcase
         end
         // Timer mode leaves the pin free.
         MODE_TIMER, MODE_CAPTURE: begin
            pin_nxt = 1'b0;
            oe_nxt = 1'b0;
         end
      endcase
   end

   // Read data, valid in the cycle after the read strobe only.
   // Reads have no side effects, so software may poll the flags freely.
   always_comb begin
      rdata_nxt = REG_RESET;
      if (bus_req.rd) begin
         unique case (bus_req.addr)
            ADDR_CONTROL_ZERO: rdata_nxt[RUN_BIT] = run_r;
            ADDR_CONTROL_ONE: rdata_nxt = 8'(ctl_r);
            ADDR_COUNT_LOW: rdata_nxt = cnt_r[7:0];
            ADDR_COUNT_HIGH: rdata_nxt[1:0] = cnt_r[9:8];
            ADDR_CMPA_LOW: rdata_nxt = cmpa_r[7:0];
            ADDR_CMPA_HIGH: rdata_nxt[1:0] = cmpa_r[9:8];
            ADDR_PERIOD_LOW: rdata_nxt = per_r[7:0];
            ADDR_PERIOD_HIGH: rdata_nxt[1:0] = per_r[9:8];
            ADDR_STATUS: begin
               rdata_nxt[FLAG_A_BIT] = flag_a_r;
               rdata_nxt[FLAG_P_BIT] = flag_p_r;
            end
            default: rdata_nxt = REG_RESET;
         endcase
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         run_r <= 1'b0;
         run_prev_r <= 1'b0;
         cnt_r <= CNT_RESET;
         cmpa_r <= CNT_RESET;
         per_r <= CNT_RESET;
         ctl_r <= ptm_ctl_t'(REG_RESET);
         flag_a_r <= 1'b0;
         flag_p_r <= 1'b0;
         lvl_r <= 1'b0;
         pin_r <= 1'b0;
         oe_r <= 1'b0;
         rdata_r <= REG_RESET;
      end else begin
         run_r <= run_nxt;
         run_prev_r <= run_prev_nxt;
         cnt_r <= cnt_nxt;
         cmpa_r <= cmpa_nxt;
         per_r <= per_nxt;
         ctl_r <= ctl_nxt;
         flag_a_r <= flag_a_nxt;
         flag_p_r <= flag_p_nxt;
         lvl_r <= lvl_nxt;
         pin_r <= pin_nxt;
         oe_r <= oe_nxt;
         rdata_r <= rdata_nxt;
      end
   end

   // The pin lags the counter by one cycle; acceptable against a slow load.
   assign rdata = rdata_r;
   assign timer_output_pin = pin_r;
   assign timer_output_oe = oe_r;
   assign match_a_flag = flag_a_r;
   assign match_p_flag = flag_p_r;

endmodule

`default_nettype wire

//--- tb/ptm_trig_model.sv
// Trigger pin source that gives one clean rising edge per request.
`timescale 1ns/100ps
`default_nettype none
module ptm_trig_model (
   input wire logic clk,
   input wire logic fire,
   output logic trig
);
   logic [2:0] hold_r = 3'h0;
   // Long high time so the synchroniser cannot miss it.
   always @(posedge clk) begin
      if (fire) begin
         hold_r <= 3'h4;
      end else if (hold_r != 3'h0) begin
         hold_r <= hold_r - 3'h1;
      end
   end
   assign trig = hold_r != 3'h0;
endmodule
`default_nettype wire

//--- tb/ptm_top_checker.sv
// Port-level assertions for the periodic timer unit.
`timescale 1ns/100ps
`default_nettype none
module ptm_top_checker
   import ptm_pkg::*;
(
   input wire logic clk,
   input wire logic resetn,
   input wire ptm_bus_t bus_req,
   input wire logic [7:0] rdata,
   input wire logic external_trigger_pin,
   input wire logic timer_output_pin,
   input wire logic timer_output_oe,
   input wire logic match_a_flag,
   input wire logic match_p_flag
);
   ptm_ctl_t ctl_r;
   logic run_r;
   logic wr0;
   logic wst;
   default clocking @(posedge clk); endclocking
   default disable iff (!resetn);
   assign wr0 = bus_req.wr && bus_req.addr == ADDR_CONTROL_ZERO;
   assign wst = bus_req.wr && bus_req.addr == ADDR_STATUS;
   // Software only mirror; hardware run clears are not tracked.
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         ctl_r <= ptm_ctl_t'(8'h00);
         run_r <= 1'b0;
      end else begin
         if (bus_req.wr && bus_req.addr == ADDR_CONTROL_ONE) begin
            ctl_r <= ptm_ctl_t'(bus_req.wdata);
         end
         if (wr0) begin
            run_r <= bus_req.wdata[RUN_BIT];
         end
      end
   end
   a_cnt_high_rsv: assert property (
      bus_req.rd && bus_req.addr == ADDR_COUNT_HIGH |=> rdata[7:2] == 6'h00)
      else $error("count high reserved bits set");
   a_cmpa_high_rsv: assert property (
      bus_req.rd && bus_req.addr == ADDR_CMPA_HIGH |=> rdata[7:2] == 6'h00)
      else $error("compare high reserved bits set");
   a_per_high_rsv: assert property (
      bus_req.rd && bus_req.addr == ADDR_PERIOD_HIGH |=> !(|rdata[7:2]))
      else $error("period high reserved bits set");
   a_timer_no_oe: assert property (
      ctl_r.mode == MODE_TIMER && $past(ctl_r.mode) == MODE_TIMER
      |-> !timer_output_oe) else $error("pin driven in timer mode");
   a_pin_released: assert property (
      !timer_output_oe |-> !timer_output_pin) else $error("pin undriven high");
   a_aflag_hold: assert property (
      match_a_flag && !(wst && bus_req.wdata[FLAG_A_BIT]) |=> match_a_flag)
      else $error("A flag lost");
   a_pflag_hold: assert property (
      $rose(match_p_flag) && !(wst && bus_req.wdata[FLAG_P_BIT])
      |=> match_p_flag) else $error("P flag lost");
   a_no_pflag: assert property (
      ctl_r.cclr && ctl_r.mode == MODE_COMPARE && $stable(ctl_r)
      |-> !$rose(match_p_flag)) else $error("P flag with A clear");
   a_run_restore: assert property (
      wr0 && bus_req.wdata[RUN_BIT] && !run_r && ctl_r.mode == MODE_COMPARE
      |-> ##[1:3] timer_output_pin == (ctl_r.oc ^ ctl_r.inv))
      else $error("pin not restored on run");
   c_flag_a: cover property ($rose(match_a_flag));
   c_flag_p: cover property ($rose(match_p_flag));
   c_pin_move: cover property ($changed(timer_output_pin));
endmodule
`default_nettype wire

//--- tb/ptm_top_test.sv
// Self-checking bench for the periodic timer unit.
`timescale 1ns/100ps
`default_nettype none
module ptm_top_test
   import ptm_pkg::*;
;
   logic clk = 1'b0;
   logic resetn = 1'b0;
   ptm_bus_t bus_req = '0;
   logic fire = 1'b0;
   logic trig;
   logic [7:0] rdata;
   logic pin, oe, fa, fp;
   int fails = 0;
   int total_checks = 0;
   int cyc = 0;
   always #25 clk = ~clk;
   ptm_top dut (.clk(clk), .resetn(resetn), .bus_req(bus_req),
      .rdata(rdata), .external_trigger_pin(trig), .timer_output_pin(pin),
      .timer_output_oe(oe), .match_a_flag(fa), .match_p_flag(fp));
   ptm_trig_model trig_src (.clk(clk), .fire(fire), .trig(trig));
   task automatic finish_test;
      $display("checks %0d fails %0d", total_checks, fails);
      if (fails == 0 && total_checks > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   task automatic chk(input logic [10:0] got, input logic [10:0] exp);
      total_checks++;
      if (got !== exp) begin
         fails++;
         $display("wrong value at %0t: got %h want %h", $time, got, exp);
      end
   endtask
   task automatic chk1(input logic got, input logic exp);
      chk({10'h000, got}, {10'h000, exp});
   endtask
   // Every bus task starts just after a rising edge and ends on one.
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      bus_req <= '{a, d, 1'b1, 1'b0};
      @(posedge clk);
      bus_req <= '0;
      @(posedge clk);
   endtask
   task automatic rd(input logic [3:0] a, output logic [7:0] d);
      bus_req <= '{a, 8'h00, 1'b0, 1'b1};
      @(posedge clk);
      bus_req <= '0;
      @(posedge clk);
      d = rdata;
   endtask
   task automatic rdck(input logic [3:0] a, input logic [7:0] e);
      logic [7:0] d;
      rd(a, d);
      chk({3'h0, d}, {3'h0, e});
   endtask
   task automatic wait_flag(input logic p, input int n);
      for (int i = 0; i < n; i++) begin
         if ((p ? fp : fa) === 1'b1) break;
         @(posedge clk);
      end
      chk1(p ? fp : fa, 1'b1);
   endtask
   task automatic cfg(input logic [7:0] c, input logic [9:0] a,
      input logic [9:0] p);
      wr(ADDR_CONTROL_ZERO, 8'h00);
      wr(ADDR_CONTROL_ONE, c);
      wr(ADDR_CMPA_LOW, a[7:0]);
      wr(ADDR_CMPA_HIGH, {6'h00, a[9:8]});
      wr(ADDR_PERIOD_LOW, p[7:0]);
      wr(ADDR_PERIOD_HIGH, {6'h00, p[9:8]});
      wr(ADDR_STATUS, 8'h03);
      wr(ADDR_CONTROL_ZERO, 8'h08);
   endtask
   task automatic t_regs;
      for (int a = 2; a <= 8; a++) rdck(4'(a), 8'h00);
      rdck(4'hF, 8'h00);
      wr(ADDR_CMPA_LOW, 8'hA5);
      wr(ADDR_CMPA_HIGH, 8'hFF);
      wr(ADDR_PERIOD_LOW, 8'h5A);
      wr(ADDR_PERIOD_HIGH, 8'hFE);
      wr(ADDR_COUNT_LOW, 8'h77);
      rdck(ADDR_CMPA_LOW, 8'hA5);
      rdck(ADDR_CMPA_HIGH, 8'h03);
      rdck(ADDR_PERIOD_LOW, 8'h5A);
      rdck(ADDR_PERIOD_HIGH, 8'h02);
      rdck(ADDR_COUNT_LOW, 8'h00);
      $display("regs done");
   endtask
   task automatic t_cmp;
      logic [1:0] act;
      for (int i = 0; i < 4; i++) begin
         act = 2'(i);
         cfg({MODE_COMPARE, act, ~act[1], 3'h0}, 10'h004, 10'h009);
         repeat (2) @(posedge clk);
         chk1(pin, ~act[1]);
         chk1(oe, 1'b1);
         wait_flag(1'b0, 20);
         repeat (2) @(posedge clk);
         chk1(pin, act != ACT_LOW);
         wait_flag(1'b1, 20);
         repeat (2) @(posedge clk);
         chk1(pin, act != ACT_LOW);
      end
      $display("compare done");
   endtask
   task automatic t_clr;
      logic [7:0] c0;
      logic [7:0] c1;
      cfg({MODE_COMPARE, ACT_NONE, 4'h1}, 10'h006, 10'h002);
      repeat (40) @(posedge clk);
      chk1(fa, 1'b1);
      chk1(fp, 1'b0);
      wr(ADDR_CONTROL_ZERO, 8'h00);
      rd(ADDR_COUNT_LOW, c0);
      repeat (5) @(posedge clk);
      rd(ADDR_COUNT_LOW, c1);
      chk({3'h0, c1}, {3'h0, c0});
      chk1(c0 < 8'h07, 1'b1);
      wr(ADDR_CONTROL_ZERO, 8'h08);
      rd(ADDR_COUNT_LOW, c1);
      chk1(c1 < 8'h03, 1'b1);
      cfg({MODE_COMPARE, ACT_NONE, 4'h1}, 10'h000, 10'h000);
      repeat (800) @(posedge clk);
      rdck(ADDR_COUNT_HIGH, 8'h03);
      repeat (400) @(posedge clk);
      chk1(fa, 1'b0);
      rdck(ADDR_COUNT_HIGH, 8'h00);
      cfg({MODE_TIMER, ACT_HIGH, 4'h8}, 10'h003, 10'h005);
      wait_flag(1'b1, 20);
      chk1(fa, 1'b1);
      chk1(oe, 1'b0);
      $display("clear done");
   endtask
   task automatic t_pwm;
      logic [7:0] ctl [7] = '{8'hA9, 8'hA9, 8'hAD, 8'hA1, 8'h89, 8'h99, 8'hA9};
      int a [7] = '{3, 8, 3, 3, 3, 3, 256};
      int p [7] = '{8, 8, 8, 8, 8, 8, 0};
      int e [7] = '{12, 32, 20, 20, 0, 32, 256};
      logic [10:0] hi;
      for (int i = 0; i < 7; i++) begin
         cfg(ctl[i], 10'(a[i]), 10'(p[i]));
         repeat (4) @(posedge clk);
         hi = 11'h000;
         repeat (i == 6 ? 1024 : 32) begin
            @(posedge clk);
            hi = hi + {10'h000, pin === 1'b1};
         end
         chk(hi, 11'(e[i]));
         if (a[i] != p[i]) begin
            chk1(fa, 1'b1);
            chk1(fp, 1'b1);
         end
      end
      $display("pwm done");
   endtask
   task automatic t_sp;
      logic [7:0] d;
      cfg(8'hB8, 10'h00A, 10'h003);
      repeat (2) @(posedge clk);
      chk1(pin, 1'b1);
      wait_flag(1'b0, 20);
      repeat (3) @(posedge clk);
      chk1(pin, 1'b0);
      rd(ADDR_CONTROL_ZERO, d);
      chk1(d[RUN_BIT], 1'b0);
      wr(ADDR_STATUS, 8'h03);
      fire <= 1'b1;
      @(posedge clk);
      fire <= 1'b0;
      repeat (5) @(posedge clk);
      rd(ADDR_CONTROL_ZERO, d);
      chk1(d[RUN_BIT], 1'b1);
      chk1(pin, 1'b1);
      wait_flag(1'b0, 30);
      wr(ADDR_CONTROL_ZERO, 8'h08);
      @(posedge clk);
      chk1(pin, 1'b1);
      wr(ADDR_CONTROL_ZERO, 8'h00);
      repeat (3) @(posedge clk);
      chk1(pin, 1'b0);
      $display("single pulse done");
   endtask
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 10000) begin
         fails = fails + 1;
         finish_test;
      end
   end
   initial begin
      repeat (3) @(posedge clk);
      resetn <= 1'b1;
      @(posedge clk);
      t_regs;
      t_cmp;
      t_clr;
      t_pwm;
      t_sp;
      finish_test;
   end
endmodule
bind ptm_top ptm_top_checker chk_i (.clk(clk), .resetn(resetn),
   .bus_req(bus_req), .rdata(rdata),
   .external_trigger_pin(external_trigger_pin),
   .timer_output_pin(timer_output_pin), .timer_output_oe(timer_output_oe),
   .match_a_flag(match_a_flag), .match_p_flag(match_p_flag));
`default_nettype wire
